// ===== hdl/pmmc_regs.sv
`timescale 1ns/100ps
`include "pmmc_defines.svh"
// Function
// - right beep gain waits for crossing/timeout
// - gain code 0 mutes, 1..15 steps, reset 0
// - left mixer: bit5 DAC mute, [4:1] gain
// - right mixer: bit6 DAC mute, [4:1] gain
// - mono mixer bits 7/6 mute DACs only
// - mono beep gain waits crossing/timeout
// - mono line mute bit0 active low
// - clamp bit0: 0 enabled, reset 0
// - clamp bit1: power mode, reset 1
// - left line mute bit1 active low
// - right line mute bit1 active low
// - line mutes never touch speaker outputs
// - timeout 20/10/5/2.5 ms forces gain
// - DAC mute applied one cycle after write
module pmmc_regs
   import pmmc_pkg::*;
#(
   parameter int unsigned TO_20MS_CYC = `PMMC_TO_20MS_US * `PMMC_CLK_MHZ
) (
   // clock and reset
   input  wire logic          clk_in,
   input  wire logic          rst_in,
   input  wire logic          ce_in,
   // register port from the serial control interface
   input  wire logic          wr_in,
   input  wire logic          rd_in,
   input  wire logic [15:0]   addr_in,
   input  wire logic [7:0]    wdata_in,
   output logic [7:0]         rdata_out,
   output logic               rvalid_out,
   // zero-crossing detector context
   input  wire logic          zc_en_in,
   input  wire pmmc_timeout_e timeout_in,
   input  wire logic          zc_pin_in,
   // playback controls (mutes: 1 = unmuted)
   output logic               left_dac_unmute_out,
   output logic               right_dac_unmute_out,
   output logic               mono_ldac_unmute_out,
   output logic               mono_rdac_unmute_out,
   output logic               mono_line_unmute_out,
   output logic               left_line_unmute_out,
   output logic               right_line_unmute_out,
   output logic               clamp_disable_out,
   output logic               clamp_low_power_out,
   output pmmc_gain_t         left_gain_out,
   output pmmc_gain_t         right_gain_out,
   output pmmc_gain_t         mono_gain_out
);
   initial begin
      if (TO_20MS_CYC < 8) $error("pmmc_regs: TO_20MS_CYC too small");
   end

   //------------------------------------------------------------
   // register storage
   //------------------------------------------------------------
   logic       lmute_r, rmute_r, mlmute_r, mrmute_r, mline_r;
   logic       lline_r, rline_r, cdis_r, clp_r;
   pmmc_gain_t lgain_r, rgain_r, mgain_r;
   logic       zc_m_r, zc_s_r, zc_d_r;
   logic       zc_edge;
   pmmc_gain_t lg_act, rg_act, mg_act;

   // decoded writes, mutes reach the outputs one cycle after the write
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         lmute_r  <= `PMMC_MUTE_RESET;
         rmute_r  <= `PMMC_MUTE_RESET;
         mlmute_r <= `PMMC_MUTE_RESET;
         mrmute_r <= `PMMC_MUTE_RESET;
         mline_r  <= `PMMC_MUTE_RESET;
         lline_r  <= `PMMC_MUTE_RESET;
         rline_r  <= `PMMC_MUTE_RESET;
         cdis_r   <= `PMMC_CLAMP_DIS_RESET;
         clp_r    <= `PMMC_CLAMP_LP_RESET;
         lgain_r  <= `PMMC_GAIN_RESET;
         rgain_r  <= `PMMC_GAIN_RESET;
         mgain_r  <= `PMMC_GAIN_RESET;
      end else if (ce_in && wr_in) begin
         unique case (addr_in)
            `PMMC_ADDR_LEFT_MIX: begin
               lmute_r <= wdata_in[`PMMC_LEFT_MUTE_BIT];
               lgain_r <= wdata_in[`PMMC_STEREO_GAIN_LSB +: 4];
            end
            `PMMC_ADDR_RIGHT_MIX: begin
               rmute_r <= wdata_in[`PMMC_RIGHT_MUTE_BIT];
               rgain_r <= wdata_in[`PMMC_STEREO_GAIN_LSB +: 4];
            end
            `PMMC_ADDR_MONO_MIX: begin
               mlmute_r <= wdata_in[`PMMC_MONO_LMUTE_BIT];
               mrmute_r <= wdata_in[`PMMC_MONO_RMUTE_BIT];
               mgain_r  <= wdata_in[`PMMC_MONO_GAIN_LSB +: 4];
               mline_r  <= wdata_in[`PMMC_MONO_LINE_BIT];
            end
            `PMMC_ADDR_CLAMP: begin
               cdis_r <= wdata_in[`PMMC_CLAMP_DIS_BIT];
               clp_r  <= wdata_in[`PMMC_CLAMP_LP_BIT];
            end
            `PMMC_ADDR_LLINE: lline_r <= wdata_in[`PMMC_LINE_MUTE_BIT];
            `PMMC_ADDR_RLINE: rline_r <= wdata_in[`PMMC_LINE_MUTE_BIT];
            default: ;
         endcase
      end
   end

   //------------------------------------------------------------
   // read back, reserved bits zero
   //------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_out  <= 8'h00;
         rvalid_out <= 1'b0;
      end else if (ce_in) begin
         rvalid_out <= rd_in;
         if (rd_in) begin
            rdata_out <= 8'h00;
            unique case (addr_in)
               `PMMC_ADDR_LEFT_MIX: begin
                  rdata_out[`PMMC_LEFT_MUTE_BIT]             <= lmute_r;
                  rdata_out[`PMMC_STEREO_GAIN_LSB +: 4]      <= lgain_r;
               end
               `PMMC_ADDR_RIGHT_MIX: begin
                  rdata_out[`PMMC_RIGHT_MUTE_BIT]            <= rmute_r;
                  rdata_out[`PMMC_STEREO_GAIN_LSB +: 4]      <= rgain_r;
               end
               `PMMC_ADDR_MONO_MIX: begin
                  rdata_out[`PMMC_MONO_LMUTE_BIT]            <= mlmute_r;
                  rdata_out[`PMMC_MONO_RMUTE_BIT]            <= mrmute_r;
                  rdata_out[`PMMC_MONO_GAIN_LSB +: 4]        <= mgain_r;
                  rdata_out[`PMMC_MONO_LINE_BIT]             <= mline_r;
               end
               `PMMC_ADDR_CLAMP: begin
                  rdata_out[`PMMC_CLAMP_DIS_BIT]             <= cdis_r;
                  rdata_out[`PMMC_CLAMP_LP_BIT]              <= clp_r;
               end
               `PMMC_ADDR_LLINE: rdata_out[`PMMC_LINE_MUTE_BIT] <= lline_r;
               `PMMC_ADDR_RLINE: rdata_out[`PMMC_LINE_MUTE_BIT] <= rline_r;
               default: ;
            endcase
         end
      end
   end

   //------------------------------------------------------------
   // beep zero crossing: synchronise the comparator pin, detect edges
   //------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         zc_m_r <= 1'b0;
         zc_s_r <= 1'b0;
         zc_d_r <= 1'b0;
      end else if (ce_in) begin
         zc_m_r <= zc_pin_in;
         zc_s_r <= zc_m_r;
         zc_d_r <= zc_s_r;
      end
   end
   assign zc_edge = zc_s_r ^ zc_d_r;

   //------------------------------------------------------------
   // deferred gain per beep path
   //------------------------------------------------------------
   pmmc_gain_sync #(.TO_20MS_CYC(TO_20MS_CYC)) u_lgain (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
      .zc_en_in(zc_en_in), .timeout_in(timeout_in), .zc_in(zc_edge),
      .target_in(lgain_r), .gain_out(lg_act)
   );
   pmmc_gain_sync #(.TO_20MS_CYC(TO_20MS_CYC)) u_rgain (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
      .zc_en_in(zc_en_in), .timeout_in(timeout_in), .zc_in(zc_edge),
      .target_in(rgain_r), .gain_out(rg_act)
   );
   pmmc_gain_sync #(.TO_20MS_CYC(TO_20MS_CYC)) u_mgain (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
      .zc_en_in(zc_en_in), .timeout_in(timeout_in), .zc_in(zc_edge),
      .target_in(mgain_r), .gain_out(mg_act)
   );

   //------------------------------------------------------------
   // output flops; line mutes drive only line outputs
   //------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         left_dac_unmute_out   <= 1'b0;
         right_dac_unmute_out  <= 1'b0;
         mono_ldac_unmute_out  <= 1'b0;
         mono_rdac_unmute_out  <= 1'b0;
         mono_line_unmute_out  <= 1'b0;
         left_line_unmute_out  <= 1'b0;
         right_line_unmute_out <= 1'b0;
         clamp_disable_out     <= `PMMC_CLAMP_DIS_RESET;
         clamp_low_power_out   <= `PMMC_CLAMP_LP_RESET;
         left_gain_out         <= `PMMC_GAIN_RESET;
         right_gain_out        <= `PMMC_GAIN_RESET;
         mono_gain_out         <= `PMMC_GAIN_RESET;
      end else if (ce_in) begin
         left_dac_unmute_out   <= lmute_r;
         right_dac_unmute_out  <= rmute_r;
         mono_ldac_unmute_out  <= mlmute_r;
         mono_rdac_unmute_out  <= mrmute_r;
         mono_line_unmute_out  <= mline_r;
         left_line_unmute_out  <= lline_r;
         right_line_unmute_out <= rline_r;
         clamp_disable_out     <= cdis_r;
         clamp_low_power_out   <= clp_r;
         left_gain_out         <= lg_act;
         right_gain_out        <= rg_act;
         mono_gain_out         <= mg_act;
      end
   end
endmodule : pmmc_regs

// ===== include/pmmc_defines.svh
`ifndef PMMC_DEFINES_SVH
`define PMMC_DEFINES_SVH
// register addresses
`define PMMC_ADDR_LEFT_MIX   16'h401c
`define PMMC_ADDR_RIGHT_MIX  16'h401e
`define PMMC_ADDR_MONO_MIX   16'h401f
`define PMMC_ADDR_CLAMP      16'h4020
`define PMMC_ADDR_LLINE      16'h4025
`define PMMC_ADDR_RLINE      16'h4026
// field positions
`define PMMC_LEFT_MUTE_BIT   5
`define PMMC_RIGHT_MUTE_BIT  6
`define PMMC_MONO_LMUTE_BIT  7
`define PMMC_MONO_RMUTE_BIT  6
`define PMMC_MONO_LINE_BIT   0
`define PMMC_STEREO_GAIN_LSB 1
`define PMMC_MONO_GAIN_LSB   2
`define PMMC_CLAMP_DIS_BIT   0
`define PMMC_CLAMP_LP_BIT    1
`define PMMC_LINE_MUTE_BIT   1
// reset values
`define PMMC_GAIN_RESET      4'h0
`define PMMC_MUTE_RESET      1'b0
`define PMMC_CLAMP_DIS_RESET 1'b0
`define PMMC_CLAMP_LP_RESET  1'b1
// timing: timeouts in microseconds, 100 MHz clock
`define PMMC_CLK_MHZ         100
`define PMMC_TO_20MS_US      20000
`define PMMC_TO_10MS_US      10000
`define PMMC_TO_5MS_US       5000
`define PMMC_TO_2P5MS_US     2500
`endif

// ===== include/pmmc_pkg.sv
package pmmc_pkg;
   typedef logic [3:0] pmmc_gain_t;
   typedef enum logic [1:0] {
      PMMC_TO_20  = 2'b00,
      PMMC_TO_10  = 2'b01,
      PMMC_TO_5   = 2'b10,
      PMMC_TO_2P5 = 2'b11
   } pmmc_timeout_e;
   typedef enum logic [0:0] {
      PMMC_IDLE = 1'b0,
      PMMC_WAIT = 1'b1
   } pmmc_zc_state_e;
endpackage : pmmc_pkg

// ===== hdl/pmmc_gain_sync.sv
`timescale 1ns/100ps
`include "pmmc_defines.svh"
// holds one beep gain until a zero crossing or timeout
module pmmc_gain_sync
   import pmmc_pkg::*;
#(
   parameter int unsigned TO_20MS_CYC = `PMMC_TO_20MS_US * `PMMC_CLK_MHZ
) (
   // clock and reset
   input  wire logic          clk_in,
   input  wire logic          rst_in,
   input  wire logic          ce_in,
   // detector control
   input  wire logic          zc_en_in,
   input  wire pmmc_timeout_e timeout_in,
   input  wire logic          zc_in,
   // gain
   input  wire pmmc_gain_t    target_in,
   output pmmc_gain_t         gain_out
);
   localparam int unsigned CW = $clog2(TO_20MS_CYC + 1);
   initial begin
      if (TO_20MS_CYC < 8) $error("pmmc_gain_sync: TO_20MS_CYC too small");
   end

   pmmc_zc_state_e state_r;
   logic [CW-1:0]  cnt_r;
   logic [CW-1:0]  limit;
   pmmc_gain_t     gain_r;

   // timeout select, shorter choices are binary fractions of 20 ms
   always_comb begin
      unique case (timeout_in)
         PMMC_TO_20:  limit = CW'(TO_20MS_CYC);
         PMMC_TO_10:  limit = CW'(TO_20MS_CYC / 2);
         PMMC_TO_5:   limit = CW'(TO_20MS_CYC / 4);
         PMMC_TO_2P5: limit = CW'(TO_20MS_CYC / 8);
      endcase
   end

   // apply change directly, or wait for crossing or timeout
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_r <= PMMC_IDLE;
         cnt_r   <= '0;
         gain_r  <= `PMMC_GAIN_RESET;
      end else if (ce_in) begin
         if (!zc_en_in) begin
            gain_r  <= target_in;
            state_r <= PMMC_IDLE;
         end else begin
            unique case (state_r)
               PMMC_IDLE: begin
                  cnt_r <= '0;
                  if (target_in != gain_r) state_r <= PMMC_WAIT;
               end
               PMMC_WAIT: begin
                  cnt_r <= cnt_r + 1'b1;
                  if (zc_in || (cnt_r + 1'b1 >= limit)) begin
                     gain_r  <= target_in;
                     state_r <= PMMC_IDLE;
                  end
               end
            endcase
         end
      end
   end

   assign gain_out = gain_r;
endmodule : pmmc_gain_sync

// ===== sim/pmmc_checker.sv
`timescale 1ns/100ps
// ---------------------------------------------
// pmmc_checker: port-level checks on the bank
// ---------------------------------------------
module pmmc_checker
   import pmmc_pkg::*;
(
   // clock and reset
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        ce_in,
   // register port
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [15:0] addr_in,
   input wire logic [7:0]  wdata_in,
   input wire logic [7:0]  rdata_out,
   input wire logic        rvalid_out,
   input wire logic        zc_en_in,
   // playback controls
   input wire logic        left_dac_unmute_out,
   input wire logic        right_dac_unmute_out,
   input wire logic        mono_line_unmute_out,
   input wire logic        left_line_unmute_out,
   input wire logic        clamp_disable_out,
   input wire logic        clamp_low_power_out,
   input wire pmmc_gain_t  left_gain_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // accepted strobes
   wire wr_c = ce_in && wr_in;
   wire rd_c = ce_in && rd_in;
   // mute and clamp outputs follow a write two edges later
   property p_lm; wr_c && addr_in == 16'h401c |-> ##2
      left_dac_unmute_out == $past(wdata_in[5], 2); endproperty
   a_lm: assert property (p_lm) else $error("left dac mute late");
   property p_rm; wr_c && addr_in == 16'h401e |=> ##1
      right_dac_unmute_out == $past(wdata_in[6], 2); endproperty
   a_rm: assert property (p_rm) else $error("right dac mute late");
   property p_ml; wr_c && addr_in == 16'h401f |-> ##2
      mono_line_unmute_out == $past(wdata_in[0], 2); endproperty
   a_ml: assert property (p_ml) else $error("mono line mute wrong");
   property p_cd; wr_c && addr_in == 16'h4020 |-> ##2
      clamp_disable_out == $past(wdata_in[0], 2); endproperty
   a_cd: assert property (p_cd) else $error("clamp enable wrong");
   property p_ll; wr_c && addr_in == 16'h4025 |-> ##2
      left_line_unmute_out == $past(wdata_in[1], 2); endproperty
   a_ll: assert property (p_ll) else $error("left line mute wrong");
   // reserved bits of the clamp register read zero
   property p_rd; rd_c && addr_in == 16'h4020 |=>
      rvalid_out && rdata_out[7:2] == 6'h00; endproperty
   a_rd: assert property (p_rd) else $error("clamp readback wrong");
   // gain passes straight through with the detector off
   property p_lg; wr_c && addr_in == 16'h401c && !zc_en_in |-> ##3
      left_gain_out == $past(wdata_in[4:1], 3); endproperty
   a_lg: assert property (p_lg) else $error("left gain not applied");
   // values seen just after reset release
   property p_rs; $fell(rst_in) |->
      clamp_low_power_out && !clamp_disable_out; endproperty
   a_rs: assert property (p_rs) else $error("clamp reset value wrong");
endmodule : pmmc_checker
bind pmmc_regs pmmc_checker i_checker (
   .clk_in               (clk_in),
   .rst_in               (rst_in),
   .ce_in                (ce_in),
   .wr_in                (wr_in),
   .rd_in                (rd_in),
   .addr_in              (addr_in),
   .wdata_in             (wdata_in),
   .rdata_out            (rdata_out),
   .rvalid_out           (rvalid_out),
   .zc_en_in             (zc_en_in),
   .left_dac_unmute_out  (left_dac_unmute_out),
   .right_dac_unmute_out (right_dac_unmute_out),
   .mono_line_unmute_out (mono_line_unmute_out),
   .left_line_unmute_out (left_line_unmute_out),
   .clamp_disable_out    (clamp_disable_out),
   .clamp_low_power_out  (clamp_low_power_out),
   .left_gain_out        (left_gain_out)
);

// ===== sim/testbench.sv
`timescale 1ns/100ps
// ---------------------------------------------
// testbench: register bank of the playback stage
// ---------------------------------------------
module testbench;
   import pmmc_pkg::*;
   localparam int unsigned TO_CYC = 80;
   logic          clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
   logic [15:0]   addr_in = 16'h0000;
   logic [7:0]    wdata_in = 8'h00, rdata_out;
   logic          zc_en_in = 1'b0, zc_pin_in = 1'b0, rvalid_out;
   pmmc_timeout_e timeout_in = PMMC_TO_20;
   logic          left_dac_unmute_out, right_dac_unmute_out, mono_ldac_unmute_out;
   logic          mono_rdac_unmute_out, mono_line_unmute_out, left_line_unmute_out;
   logic          right_line_unmute_out, clamp_disable_out, clamp_low_power_out;
   pmmc_gain_t    left_gain_out, right_gain_out, mono_gain_out;
   int            mismatches = 0, comparisons = 0, cycles = 0;
   logic [15:0]   addrs [6] = '{16'h401c, 16'h401e, 16'h401f, 16'h4020, 16'h4025, 16'h4026};
   // write data: reserved bits set, gains one step up, clamp left enabled
   logic [7:0]    wdat  [6] = '{8'he3, 8'he3, 8'hc7, 8'hfe, 8'hff, 8'hff};
   logic [7:0]    masks [6] = '{8'h22, 8'h42, 8'hc5, 8'h02, 8'h02, 8'h02};
   wire  [7:0]    mutes = {left_dac_unmute_out, right_dac_unmute_out, mono_ldac_unmute_out,
      mono_rdac_unmute_out, mono_line_unmute_out, left_line_unmute_out,
      right_line_unmute_out, clamp_disable_out};
   pmmc_regs #(.TO_20MS_CYC(TO_CYC)) i_dut (
      .clk_in                (clk_in),
      .rst_in                (rst_in),
      .ce_in                 (ce_in),
      .wr_in                 (wr_in),
      .rd_in                 (rd_in),
      .addr_in               (addr_in),
      .wdata_in              (wdata_in),
      .rdata_out             (rdata_out),
      .rvalid_out            (rvalid_out),
      .zc_en_in              (zc_en_in),
      .timeout_in            (timeout_in),
      .zc_pin_in             (zc_pin_in),
      .left_dac_unmute_out   (left_dac_unmute_out),
      .right_dac_unmute_out  (right_dac_unmute_out),
      .mono_ldac_unmute_out  (mono_ldac_unmute_out),
      .mono_rdac_unmute_out  (mono_rdac_unmute_out),
      .mono_line_unmute_out  (mono_line_unmute_out),
      .left_line_unmute_out  (left_line_unmute_out),
      .right_line_unmute_out (right_line_unmute_out),
      .clamp_disable_out     (clamp_disable_out),
      .clamp_low_power_out   (clamp_low_power_out),
      .left_gain_out         (left_gain_out),
      .right_gain_out        (right_gain_out),
      .mono_gain_out         (mono_gain_out)
   );
   // clock and hang guard
   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         results();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : tick
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      wr_in = 1'b1;
      addr_in = a;
      wdata_in = d;
      tick(1);
      wr_in = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      rd_in = 1'b1;
      addr_in = a;
      tick(1);
      rd_in = 1'b0;
      chk("rvalid", 8'h01, {7'h00, rvalid_out});
      chk("rdata", e, rdata_out);
   endtask : rd
   // reset values at the ports and in the clamp register
   task automatic t_reset();
      chk("mutes", 8'h00, mutes);
      chk("clamp lp", 8'h01, {7'h00, clamp_low_power_out});
      chk("gains", 8'h00, {left_gain_out, right_gain_out});
      rd(16'h4020, 8'h02);
   endtask : t_reset
   // every register set then cleared, clamp off only with lines muted, plus an unmapped place
   task automatic t_regs();
      for (int i = 0; i < 6; i++) begin
         wr(addrs[i], wdat[i]);
         rd(addrs[i], masks[i]);
      end
      wr(16'h4021, 8'hff);
      rd(16'h4021, 8'h00);
      chk("mutes on", 8'hfe, mutes);
      for (int i = 0; i < 6; i++) begin
         wr(addrs[i], 8'h00);
         tick(1);
      end
      wr(16'h4020, 8'h01);
      tick(2);
      chk("clamp off", 8'h01, {7'h00, clamp_disable_out});
      wr(16'h4020, 8'h00);
      tick(2);
      chk("mutes off", 8'h00, mutes);
      chk("clamp hp", 8'h00, {7'h00, clamp_low_power_out});
   endtask : t_regs
   // right gain waits for a crossing
   task automatic t_zc();
      zc_en_in = 1'b1;
      wr(16'h401e, 8'h02);
      tick(4);
      chk("right hold", 8'h00, {4'h0, right_gain_out});
      zc_pin_in = ~zc_pin_in;
      tick(6);
      chk("right gain", 8'h01, {4'h0, right_gain_out});
   endtask : t_zc
   // writes are ignored while the clock enable is low
   task automatic t_ce();
      ce_in = 1'b0;
      wr(16'h4025, 8'h02);
      ce_in = 1'b1;
      tick(2);
      chk("ce hold", 8'h00, {7'h00, left_line_unmute_out});
   endtask : t_ce
   // mono gain forced by each timeout choice
   task automatic t_timeout();
      for (int t = 0; t < 4; t++) begin
         timeout_in = pmmc_timeout_e'(t);
         wr(16'h401f, {2'b00, 4'(t + 1), 2'b00});
         tick((TO_CYC >> t) / 2);
         chk("mono hold", {4'h0, 4'(t)}, {4'h0, mono_gain_out});
         tick(TO_CYC >> t);
         chk("mono gain", {4'h0, 4'(t + 1)}, {4'h0, mono_gain_out});
      end
   endtask : t_timeout
   task automatic results();
      if (mismatches == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   // main sequence
   initial begin
      tick(2);
      rst_in = 1'b0;
      t_reset();
      t_regs();
      t_ce();
      t_zc();
      t_timeout();
      results();
   end
endmodule : testbench
